//--- hdl/manchester_frame_decoder_regs.vh
// Constants for the Manchester frame decoder: readout map, field positions, timing.
//
// Overview of operation
// - Two machines: bit recovery and frame parsing.
// - Dwell counter counts per state, clears on change.
// - Five-cycle delay hides bit-boundary line transitions.
// - Newest recovered bit enters position zero unless halted or full.
// - One shift register holds preamble, then data.
// - Parser matches preamble before capturing any data.
// - Preamble match reloads register with value one.
// - Marker at position 96 freezes register until reset.
// - Four-bit address selects byte; 0xc-0xf read zero.
`ifndef MANCHESTER_FRAME_DECODER_REGS_VH
`define MANCHESTER_FRAME_DECODER_REGS_VH

// Readout addresses of the captured bytes and of the parser state.
`define ADDR_SENDER_ID_BYTE0        4'h0
`define ADDR_SENDER_ID_BYTE1        4'h1
`define ADDR_SENDER_ID_BYTE2        4'h2
`define ADDR_SENDER_ID_BYTE3        4'h3
`define ADDR_MEASURED_TEMP_LOW      4'h4
`define ADDR_MEASURED_TEMP_HIGH     4'h5
`define ADDR_TARGET_TEMP_LOW        4'h6
`define ADDR_TARGET_TEMP_HIGH       4'h7
`define ADDR_PARSER_STATE           4'h8
`define ADDR_TRAILER_BYTE1          4'h9
`define ADDR_TRAILER_BYTE2          4'ha
`define ADDR_TRAILER_BYTE3          4'hb

// Low bit of each byte inside the captured half frame (first received sits highest).
`define POS_SENDER_ID               64
`define POS_SENDER_ID_BYTE1         72
`define POS_SENDER_ID_BYTE2         80
`define POS_SENDER_ID_BYTE3         88
`define POS_MEASURED_TEMP_HIGH      56
`define POS_TARGET_TEMP_HIGH        40
`define POS_MEASURED_TEMP           48
`define POS_TARGET_TEMP             32
`define POS_STATE_BYTE              24
`define POS_TRAILER1                16
`define POS_TRAILER2                8
`define POS_TRAILER3                0

// Shift register geometry: marker position and total width.
`define SHIFT_LAST                  96
`define SHIFT_WIDTH                 97
`define SHIFT_RELOAD                97'h1

// Preamble pattern tested on the newest bits while hunting.
`define PREAMBLE_WIDTH              32
`define PREAMBLE_PATTERN            32'haaaa_aaa9

// Delay after a data transition, in clock cycles.
`define MID_BIT_DELAY               8'h05
`define DWELL_WIDTH                 8

// Bit recovery states.
`define RX_LOW_WAIT                 2'h0
`define RX_LOW_READY                2'h1
`define RX_HIGH_WAIT                2'h2
`define RX_HIGH_READY               2'h3

// Parser states.
`define PS_HUNT                     2'h0
`define PS_CAPTURE                  2'h1
`define PS_FULL                     2'h2

`endif

//--- hdl/manchester_bit_recovery.v
// Manchester bit recovery machine: turns a clean line level into recovered bits.
`timescale 1ns/1ps
`default_nettype none
`include "manchester_frame_decoder_regs.vh"

module manchester_bit_recovery (
    // Clock and reset.
    input  wire       i_mclk,
    input  wire       i_nrst,
    // Filtered line level.
    input  wire       i_line,
    // Recovered bit stream and edge pulses.
    output reg        o_bit_valid,
    output reg        o_bit_value,
    output reg        o_rise,
    output reg        o_fall
);

    reg  [1:0]                state_r;    // Current recovery state.
    reg  [1:0]                state_nxt;  // Next recovery state.
    reg  [`DWELL_WIDTH-1:0]   dwell_r;    // Cycles spent in the current state.
    reg                       line_r;     // Line level one cycle ago.
    reg                       emit_nxt;   // A data bit is recovered this cycle.
    wire                      rise;       // Line went high.
    wire                      fall;       // Line went low.
    wire                      delay_done; // Mid-bit guard time is over.

    assign rise       = i_line & ~line_r;
    assign fall       = ~i_line & line_r;
    assign delay_done = (dwell_r >= (`MID_BIT_DELAY - 8'h01));

    // Next state: a transition while waiting is a boundary edge and carries no data;
    // a transition once ready is the data edge, rising meaning one.
    always @* begin
        state_nxt = state_r;
        emit_nxt  = 1'b0;
        case (state_r)
            `RX_LOW_WAIT: begin
                if (rise) begin
                    state_nxt = `RX_HIGH_READY;
                end else if (delay_done) begin
                    state_nxt = `RX_LOW_READY;
                end
            end
            `RX_HIGH_WAIT: begin
                if (fall) begin
                    state_nxt = `RX_LOW_READY;
                end else if (delay_done) begin
                    state_nxt = `RX_HIGH_READY;
                end
            end
            `RX_LOW_READY: begin
                if (rise) begin
                    state_nxt = `RX_HIGH_WAIT;
                    emit_nxt  = 1'b1;
                end
            end
            `RX_HIGH_READY: begin
                if (fall) begin
                    state_nxt = `RX_LOW_WAIT;
                    emit_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = `RX_LOW_READY;
            end
        endcase
    end

    // State, dwell counter and registered outputs.
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r     <= `RX_LOW_READY;
            dwell_r     <= {`DWELL_WIDTH{1'b0}};
            line_r      <= 1'b0;
            o_bit_valid <= 1'b0;
            o_bit_value <= 1'b0;
            o_rise      <= 1'b0;
            o_fall      <= 1'b0;
        end else begin
            state_r <= state_nxt;
            line_r  <= i_line;
            if (state_nxt != state_r) begin
                dwell_r <= {`DWELL_WIDTH{1'b0}};
            end else if (dwell_r != {`DWELL_WIDTH{1'b1}}) begin
                dwell_r <= dwell_r + 8'h01;
            end
            o_bit_valid <= emit_nxt;
            if (emit_nxt) begin
                o_bit_value <= rise;
            end
            o_rise <= rise;
            o_fall <= fall;
        end
    end

endmodule
`default_nettype wire

//--- hdl/manchester_frame_decoder.v
// Top of the Manchester frame decoder: pin sync, frame parser and byte readout.
`timescale 1ns/1ps
`default_nettype none
`include "manchester_frame_decoder_regs.vh"

module manchester_frame_decoder (
    // Clock and reset.
    input  wire       i_mclk,
    input  wire       i_nrst,
    // Serial line from the radio receiver.
    input  wire       i_serial_in,
    // Pause of shift register loads.
    input  wire       i_halt,
    // Readout address.
    input  wire [3:0] i_addr,
    // Readout data.
    output reg  [7:0] o_parallel_out,
    // Status outputs.
    output reg        o_full,
    output reg        o_bit_clock,
    output reg        o_bit_data,
    output reg        o_frame_start,
    output reg        o_neg_edge,
    output reg        o_pos_edge
);

    // Every pin is asynchronous to the system clock, so all of them share one
    // synchroniser bank; the address bits may settle a cycle apart from each other.
    localparam NUM_PINS = 6;                 // Synchronised pins: line, halt, address.

    // Pin synchronisers.
    wire [NUM_PINS-1:0]      pins_raw;       // Raw pin levels.
    reg  [NUM_PINS-1:0]      pins_s1_r;      // First stage.
    reg  [NUM_PINS-1:0]      pins_s2_r;      // Second stage.
    reg  [NUM_PINS-1:0]      pins_s3_r;      // Third stage.
    reg  [NUM_PINS-1:0]      pins_r;         // Accepted level.

    // Recovered bits.
    wire                     bit_valid;      // One-cycle pulse per recovered bit.
    wire                     bit_value;      // Value of the recovered bit.
    wire                     rise;           // Rising line pulse.
    wire                     fall;           // Falling line pulse.

    // Parser.
    reg  [1:0]               pstate_r;       // Parser state.
    reg  [1:0]               pstate_nxt;     // Next parser state.
    reg  [`SHIFT_WIDTH-1:0]  shift_r;        // Shared preamble and data register.
    reg  [`SHIFT_WIDTH-1:0]  shift_nxt;      // Next shift register value.
    reg                      start_nxt;      // Preamble found this cycle.
    wire [`SHIFT_WIDTH-1:0]  shifted;        // Register with the new bit shifted in.
    wire                     line;           // Clean serial level.
    wire                     halt;           // Clean halt level.
    wire [3:0]               addr;           // Clean address.

    assign pins_raw = {i_addr, i_halt, i_serial_in};
    assign line     = pins_r[0];
    assign halt     = pins_r[1];
    assign addr     = pins_r[5:2];

    // Three-flop synchronisers; a level is accepted once stages two and three agree.
    // The agreement test keeps a one-cycle glitch off the accepted level, so a spike
    // on the radio line cannot pose as a transition.
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_sync
            always @(posedge i_mclk or negedge i_nrst) begin
                if (!i_nrst) begin
                    pins_s1_r[g] <= 1'b0;
                    pins_s2_r[g] <= 1'b0;
                    pins_s3_r[g] <= 1'b0;
                    pins_r[g]    <= 1'b0;
                end else begin
                    pins_s1_r[g] <= pins_raw[g];
                    pins_s2_r[g] <= pins_s1_r[g];
                    pins_s3_r[g] <= pins_s2_r[g];
                    // Only agreeing stages update the accepted level.
                    if (pins_s2_r[g] == pins_s3_r[g]) begin
                        pins_r[g] <= pins_s3_r[g];
                    end
                end
            end
        end
    endgenerate

    // Its edge pulses and bit pulses are registered, so the parser sees a bit one
    // cycle after the accepted line level moves; the status pins add one more cycle.
    // Bit recovery machine.
    manchester_bit_recovery u_bit_recovery (
        .i_mclk      (i_mclk),
        .i_nrst      (i_nrst),
        .i_line      (line),
        .o_bit_valid (bit_valid),
        .o_bit_value (bit_value),
        .o_rise      (rise),
        .o_fall      (fall)
    );

    // Each recovered bit enters at the bottom and pushes the older bits upward.
    // Newest bit at zero.
    assign shifted = {shift_r[`SHIFT_WIDTH-2:0], bit_value};

    // Returns the byte of the captured half frame that starts at a given bit.
    // Only fixed positions are passed, so the slice never leaves the register.
    function [7:0] field_byte;
        input [`SHIFT_WIDTH-1:0] frame;
        input integer            pos;
        begin
            field_byte = frame[pos +: 8];
        end
    endfunction

    // Selects the readout byte for an address; unused addresses give zero.
    // The parser state is shown live, so a reader can poll it while a frame arrives.
    function [7:0] read_mux;
        input [3:0]              a;
        input [`SHIFT_WIDTH-1:0] frame;
        input [1:0]              st;
        begin
            case (a)
                `ADDR_SENDER_ID_BYTE0:   read_mux = field_byte(frame, `POS_SENDER_ID);
                `ADDR_SENDER_ID_BYTE1:   read_mux = field_byte(frame, `POS_SENDER_ID_BYTE1);
                `ADDR_SENDER_ID_BYTE2:   read_mux = field_byte(frame, `POS_SENDER_ID_BYTE2);
                `ADDR_SENDER_ID_BYTE3:   read_mux = field_byte(frame, `POS_SENDER_ID_BYTE3);
                `ADDR_MEASURED_TEMP_LOW: read_mux = field_byte(frame, `POS_MEASURED_TEMP);
                `ADDR_MEASURED_TEMP_HIGH: read_mux = field_byte(frame, `POS_MEASURED_TEMP_HIGH);
                `ADDR_TARGET_TEMP_LOW:   read_mux = field_byte(frame, `POS_TARGET_TEMP);
                `ADDR_TARGET_TEMP_HIGH:  read_mux = field_byte(frame, `POS_TARGET_TEMP_HIGH);
                // The state code is zero-extended: hunt, capture, full.
                `ADDR_PARSER_STATE:      read_mux = {6'h00, st};
                `ADDR_TRAILER_BYTE1:     read_mux = field_byte(frame, `POS_TRAILER1);
                `ADDR_TRAILER_BYTE2:     read_mux = field_byte(frame, `POS_TRAILER2);
                `ADDR_TRAILER_BYTE3:     read_mux = field_byte(frame, `POS_TRAILER3);
                // Addresses 0xc to 0xf read as zero.
                default:                 read_mux = 8'h00;
            endcase
        end
    endfunction

    // Hunting shifts every bit that arrives while not halted and compares the newest bits with the preamble;
    // capturing shifts until the marker arrives at the top position.
    // Frame parsing machine.
    always @* begin
        pstate_nxt = pstate_r;
        shift_nxt  = shift_r;
        start_nxt  = 1'b0;
        case (pstate_r)
            `PS_HUNT: begin
                // Halt pauses loads here and in capture; a bit seen then is dropped.
                // Register first holds preamble.
                if (bit_valid && !halt) begin
                    shift_nxt = shifted;
                    if (shifted[`PREAMBLE_WIDTH-1:0] == `PREAMBLE_PATTERN) begin
                        shift_nxt  = `SHIFT_RELOAD;
                        start_nxt  = 1'b1;
                        pstate_nxt = `PS_CAPTURE;
                    end
                end
            end
            `PS_CAPTURE: begin
                if (bit_valid && !halt) begin
                    shift_nxt = shifted;
                    if (shifted[`SHIFT_LAST]) begin
                        pstate_nxt = `PS_FULL;
                    end
                end
            end
            `PS_FULL: begin
                shift_nxt = shift_r;
            end
            default: begin
                // An unknown code can only come from an upset; restart the hunt
                // with a clean register.
                pstate_nxt = `PS_HUNT;
                shift_nxt  = {`SHIFT_WIDTH{1'b0}};
            end
        endcase
    end

    // Parser registers.
    // A reset is the only way out of the full state.
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pstate_r <= `PS_HUNT;
            shift_r  <= {`SHIFT_WIDTH{1'b0}};
        end else begin
            pstate_r <= pstate_nxt;
            shift_r  <= shift_nxt;
        end
    end

    // Registered outputs: readout byte and status pins.
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_parallel_out <= 8'h00;
            o_full         <= 1'b0;
            o_bit_clock    <= 1'b0;
            o_bit_data     <= 1'b0;
            o_frame_start  <= 1'b0;
            o_neg_edge     <= 1'b0;
            o_pos_edge     <= 1'b0;
        end else begin
            o_parallel_out <= read_mux(addr, shift_r, pstate_r);
            // Status outputs.
            // The full flag follows the next state so it rises with the final load.
            o_full        <= (pstate_nxt == `PS_FULL);
            // One pulse per recovered bit, with its value held until the next bit.
            o_bit_clock   <= bit_valid;
            if (bit_valid) begin
                o_bit_data <= bit_value;
            end
            // Frame start and edge pulses last exactly one cycle.
            o_frame_start <= start_nxt;
            o_neg_edge    <= fall;
            o_pos_edge    <= rise;
        end
    end

endmodule
`default_nettype wire

//--- test/radio_rx_model.sv
// Behavioural model of the radio receiver output that feeds the decoder.
`timescale 1ns/1ps
`default_nettype none

module radio_rx_model #(
    parameter int HALF = 4  // Half-bit length in clock cycles.
) (
    // Pacing clock.
    input  wire logic i_mclk,
    // Demodulated serial line.
    output var  logic o_line
);
    // The line idles low before any frame.
    initial o_line = 1'b0;

    // Manchester line shape
    // Sends n bits, first bit first; a one is low then high, a zero high then low.
    task automatic send(input logic [95:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            o_line = ~v[i];
            repeat (HALF) @(negedge i_mclk);
            o_line = v[i];
            repeat (HALF) @(negedge i_mclk);
        end
    endtask
endmodule

`default_nettype wire

//--- test/manchester_frame_decoder_sva.sv
// Port-level concurrent checks for the Manchester frame decoder.
`timescale 1ns/1ps
`default_nettype none

module mfd_checker (
    // Clock and reset.
    input wire logic       i_mclk,
    input wire logic       i_nrst,
    // Inputs.
    input wire logic       i_serial_in,
    input wire logic       i_halt,
    input wire logic [3:0] i_addr,
    // Outputs.
    input wire logic [7:0] o_parallel_out,
    input wire logic       o_full,
    input wire logic       o_bit_clock,
    input wire logic       o_bit_data,
    input wire logic       o_frame_start,
    input wire logic       o_neg_edge,
    input wire logic       o_pos_edge
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    full_sticky_a: assert property (o_full |=> o_full)
        else $error("full flag dropped without reset");
    start_pulse_a: assert property (o_frame_start |=> !o_frame_start)
        else $error("frame start longer than one cycle");
    start_not_full_a: assert property (o_frame_start |-> !o_full)
        else $error("frame start while frame is full");
    edge_exclusive_a: assert property (!(o_pos_edge && o_neg_edge))
        else $error("both edge pulses at once");
    rise_is_one_a: assert property (o_bit_clock && o_pos_edge |-> o_bit_data)
        else $error("rising data edge not recovered as one");
    fall_is_zero_a: assert property (o_bit_clock && o_neg_edge |-> !o_bit_data)
        else $error("falling data edge not recovered as zero");
    bit_gap_a: assert property (o_bit_clock |=> !o_bit_clock [*4])
        else $error("bit recovered inside the guard delay");
    reserved_zero_a: assert property ((i_addr[3:2] == 2'b11) [*7] |=> o_parallel_out == 8'h00)
        else $error("reserved address read nonzero");
    full_state_a: assert property ((o_full && i_addr == 4'h8) [*7] |=> o_parallel_out == 8'h02)
        else $error("full frame not shown as parser state two");

    // Main scenarios reached.
    cover property (o_frame_start);
    cover property (!o_full ##1 o_full);
    cover property (i_addr == 4'hf && o_parallel_out == 8'h00);
endmodule

bind manchester_frame_decoder mfd_checker chk_u (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_serial_in(i_serial_in), .i_halt(i_halt),
    .i_addr(i_addr), .o_parallel_out(o_parallel_out), .o_full(o_full),
    .o_bit_clock(o_bit_clock), .o_bit_data(o_bit_data), .o_frame_start(o_frame_start),
    .o_neg_edge(o_neg_edge), .o_pos_edge(o_pos_edge)
);

`default_nettype wire

//--- test/manchester_frame_decoder_tb.sv
// Self-checking testbench for the Manchester frame decoder.
`timescale 1ns/1ps
`default_nettype none

module manchester_frame_decoder_tb;
    logic       i_mclk;          // System clock.
    logic       i_nrst;          // Active-low reset.
    logic       i_halt;          // Load pause.
    logic [3:0] i_addr;          // Readout address.
    wire        i_serial_in;     // Line from the receiver model.
    wire  [7:0] o_parallel_out;  // Readout byte.
    wire        o_full, o_bit_clock, o_bit_data, o_frame_start, o_neg_edge, o_pos_edge;
    int         err_total = 0;   // Mismatches.
    int         check_count = 0; // Comparisons.
    int         fs_cnt = 0;      // Frame start pulses seen.
    int         bc_cnt = 0;      // Bit pulses seen.
    int         pe_cnt = 0;      // Rising edge pulses seen.
    int         ne_cnt = 0;      // Falling edge pulses seen.
    int         n0, n1;          // Counter snapshots.
    // Leading 0x55 lets the decoder lock on before the preamble.
    localparam logic [39:0] PRE = 40'h55_aaaa_aaa9;
    localparam logic [95:0] FRAME = 96'h44332211_6655_8877_5a_99aabb;

    // Free-running 10 MHz clock.
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    radio_rx_model #(.HALF(4)) rx_u (.i_mclk(i_mclk), .o_line(i_serial_in));

    manchester_frame_decoder dut_u (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_serial_in(i_serial_in), .i_halt(i_halt),
        .i_addr(i_addr), .o_parallel_out(o_parallel_out), .o_full(o_full),
        .o_bit_clock(o_bit_clock), .o_bit_data(o_bit_data), .o_frame_start(o_frame_start),
        .o_neg_edge(o_neg_edge), .o_pos_edge(o_pos_edge)
    );

    // All status pins gathered into one byte for comparison.
    wire  [7:0] status_bits = {2'b00, o_full, o_bit_clock, o_bit_data, o_frame_start,
                               o_neg_edge, o_pos_edge};

    // Counts the one-cycle status pulses.
    always @(posedge i_mclk) begin
        if (o_frame_start === 1'b1) fs_cnt++;
        if (o_bit_clock === 1'b1) bc_cnt++;
        if (o_pos_edge === 1'b1) pe_cnt++;
        if (o_neg_edge === 1'b1) ne_cnt++;
    end

    // Compares one byte-wide result.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Selects an address and compares the byte once the pins have settled.
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(negedge i_mclk);
        i_addr = a;
        repeat (8) @(negedge i_mclk);
        chk($sformatf("byte at %h", a), exp, o_parallel_out);
    endtask

    // Applies reset for three cycles and checks the quiet outputs.
    task automatic t_reset();
        i_nrst = 1'b0;
        repeat (3) @(negedge i_mclk);
        chk("status", 8'h00, status_bits);
        chk("readout", 8'h00, o_parallel_out);
        i_nrst = 1'b1;
        $display("reset test done");
    endtask

    // Parser state and reserved addresses before any frame.
    task automatic t_idle_read();
        rd(4'h8, 8'h00);
        for (int a = 12; a < 16; a++) rd(a[3:0], 8'h00);
        $display("idle readout test done");
    endtask

    // A preamble sent while loads are paused must not start a frame.
    task automatic t_halt();
        i_halt = 1'b1;
        repeat (10) @(negedge i_mclk);
        n0 = fs_cnt;
        rx_u.send({56'h0, PRE}, 40);
        repeat (10) @(negedge i_mclk);
        chk("start while halted", 8'h00, 8'(fs_cnt - n0));
        rd(4'h8, 8'h00);
        i_halt = 1'b0;
        repeat (10) @(negedge i_mclk);
        $display("halt test done");
    endtask

    // Full frame: preamble, 96 data bits, then every readout byte.
    task automatic t_frame();
        n0 = fs_cnt;
        rx_u.send({56'h0, PRE}, 40);
        repeat (10) @(negedge i_mclk);
        chk("start pulses", 8'h01, 8'(fs_cnt - n0));
        rd(4'h8, 8'h01);
        n1 = bc_cnt;
        rx_u.send(FRAME, 96);
        repeat (10) @(negedge i_mclk);
        chk("data bits", 8'd96, 8'(bc_cnt - n1));
        chk("full flag", 8'h01, {7'h00, o_full});
        chk("last bit", 8'h01, {7'h00, o_bit_data});
        for (int a = 0; a < 12; a++)
            rd(a[3:0], (a < 8) ? 8'(17 * (a + 1)) : (a == 8) ? 8'h02 : 8'(17 * a));
        $display("frame test done");
    endtask

    // Bits after the frame is full must not move the captured bytes.
    task automatic t_freeze();
        n0 = pe_cnt;
        n1 = ne_cnt;
        rx_u.send(96'h0, 8);
        repeat (10) @(negedge i_mclk);
        chk("rise pulses", 8'd7, 8'(pe_cnt - n0));
        chk("fall pulses", 8'd8, 8'(ne_cnt - n1));
        chk("last bit", 8'h00, {7'h00, o_bit_data});
        rd(4'h0, 8'h11);
        rd(4'hb, 8'hbb);
        $display("freeze test done");
    endtask

    // Reset re-arms capture.
    task automatic t_rearm();
        t_reset();
        rd(4'h8, 8'h00);
        chk("full after reset", 8'h00, {7'h00, o_full});
        $display("rearm test done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence.
    initial begin
        i_halt = 1'b0;
        i_addr = 4'h0;
        t_reset();
        t_idle_read();
        t_halt();
        t_frame();
        t_freeze();
        t_rearm();
        test_done();
    end

    // Watchdog well beyond the 1736 cycles the tests need.
    initial begin
        repeat (20000) @(posedge i_mclk);
        err_total++;
        test_done();
    end
endmodule

`default_nettype wire
